// ---- core/tpo_pkg.sv ----
// Package with register map, reset values and field layout of the pattern block.
package tpo_pkg;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  // ==========================================================================
  localparam logic [27:0] IDX_PORT_DATA = 28'h5FFFFC2;
  localparam logic [27:0] IDX_PIN_FUNC_HIGH = 28'h5FFFFCC;
  localparam logic [27:0] IDX_PIN_FUNC_LOW = 28'h5FFFFCE;
  localparam logic [27:0] IDX_MODE = 28'h5FFFFF0;
  localparam logic [27:0] IDX_TRIG_SEL = 28'h5FFFFF1;
  localparam logic [27:0] IDX_EN_UPPER = 28'h5FFFFF2;
  localparam logic [27:0] IDX_EN_LOWER = 28'h5FFFFF3;
  localparam logic [27:0] IDX_ND_UPPER = 28'h5FFFFF4;
  localparam logic [27:0] IDX_ND_LOWER = 28'h5FFFFF5;
  localparam logic [27:0] IDX_ND_UPPER_ALT = 28'h5FFFFF6;
  localparam logic [27:0] IDX_ND_LOWER_ALT = 28'h5FFFFF7;
  localparam logic [27:0] IDX_GAP = 28'h5FFFFF8;
  localparam logic [27:0] IDX_QUEUE = 28'h5FFFFF9;
  localparam logic [27:0] IDX_QUEUE_LEVEL = 28'h5FFFFFA;
  localparam logic [3:0] IDX_AREA = 4'h5;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [15:0] RST_PORT_DATA = 16'h0000;
  localparam logic [15:0] RST_PIN_FUNC = 16'h0000;
  localparam logic [7:0] RST_MODE = 8'hF0;
  localparam logic [7:0] RST_TRIG_SEL = 8'hFF;
  localparam logic [7:0] RST_EN = 8'h00;
  localparam logic [7:0] RST_ND = 8'h00;
  localparam logic [7:0] RST_GAP = 8'h01;

  // ==========================================================================
  // Fields and encodings
  // ==========================================================================
  localparam int GROUPS = 4;
  localparam int GROUP_BITS = 4;
  localparam int SEL_BITS = 2;
  localparam logic [1:0] PIN_FUNC_PATTERN = 2'h1;
  localparam logic [3:0] RSVD_NIBBLE = 4'hF;
  localparam logic [7:0] RSVD_BYTE = 8'hFF;
  localparam logic [7:0] GAP_ONE = 8'h01;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_WIDTH = 16;

endpackage : tpo_pkg

// ---- core/tpo_fifo.sv ----
// Synchronous FIFO that queues pattern words ahead of the next-data registers.
`timescale 1ns/1ps
`default_nettype none
module tpo_fifo
  import tpo_pkg::*;
#(
  parameter int WIDTH = FIFO_WIDTH,
  parameter int DEPTH = FIFO_DEPTH
)
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // Drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready,
  // Status
  output logic [$clog2(DEPTH):0] o_level
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } tpo_fifo_st_t;

  tpo_fifo_st_t s_ff;
  tpo_fifo_st_t nxt_s;
  logic push;
  logic pop;

  assign o_in_ready = (s_ff.count != DEPTH[AW:0]);
  assign o_out_valid = (s_ff.count != '0);
  assign o_out_data = s_ff.mem[s_ff.rd_ptr];
  assign o_level = s_ff.count;
  assign push = i_in_valid && o_in_ready;
  assign pop = i_out_ready && o_out_valid;

  always_comb
  begin
    nxt_s = s_ff;
    if (push)
    begin
      nxt_s.mem[s_ff.wr_ptr] = i_in_data;
      nxt_s.wr_ptr = s_ff.wr_ptr + 1'b1;
    end
    if (pop)
    begin
      nxt_s.rd_ptr = s_ff.rd_ptr + 1'b1;
    end
    if (push && !pop)
    begin
      nxt_s.count = s_ff.count + 1'b1;
    end
    else if (pop && !push)
    begin
      nxt_s.count = s_ff.count - 1'b1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      s_ff <= '0;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

endmodule : tpo_fifo
`default_nettype wire

// ---- core/tpo_top.sv ----
// Timing pattern output block with AHB-Lite register slave and word queue.
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// Summary of operation
// [RULE_01] Sixteen outputs form four independent 4-bit groups, 3 down to 0.
// [RULE_02] Pattern output is enabled per bit across all sixteen bits.
// [RULE_03] Each group picks its trigger from four timer compare-match inputs.
// [RULE_04] Optional non-overlap gap delays rising edges after falling ones.
// [RULE_05] Compare-matches used as triggers raise a DMA transfer request.
// [RULE_06] Pins 0-3 group 0, 4-7 group 1, 8-11 group 2, 12-15 group 3.
// [RULE_07] Software writes to pattern-enabled port data bits are ignored.
// [RULE_08] Decode uses address bits 27-24 and 8-0 only.
// [RULE_09] Shared trigger on groups 0,1: lower next data is one byte.
// [RULE_10] Split trigger: group 1 at one lower address, group 0 other.
// [RULE_11] Shared trigger on groups 2,3: upper next data is one byte.
// [RULE_12] Split trigger: group 3 at one upper address, group 2 other.
// [RULE_13] On trigger, next data copies into the port data bits.
// [RULE_14] Software sets pin function to pattern for each pattern pin.
// [RULE_15] Reserved next-data positions read as ones and ignore writes.
// [RULE_16] Trigger pulse is sampled, group updates on the following edge.
module tpo_top
  import tpo_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic [31:0] o_hrdata,
  output logic o_hresp,
  // Timer compare-match pulses
  input wire logic [3:0] i_cmp_match,
  // Pattern pins
  output logic [15:0] o_pattern,
  output logic [15:0] o_pattern_oe,
  // DMA requests
  output logic [3:0] o_dma_req
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic ap_vld;
    logic ap_wr;
    logic [8:0] ap_lo;
    logic hready;
    logic hresp;
    logic [31:0] hrdata;
    logic [15:0] pd;
    logic [15:0] pfh;
    logic [15:0] pfl;
    logic [7:0] mode;
    logic [7:0] tsel;
    logic [7:0] enu;
    logic [7:0] enl;
    logic [7:0] ndu;
    logic [7:0] ndl;
    logic [7:0] gap;
    logic [3:0] trig;
    logic [3:0] dma;
    logic [3:0][3:0] pend;
    logic [3:0][7:0] cnt;
    logic [15:0] oen;
  } tpo_st_t;

  tpo_st_t s_ff;
  tpo_st_t nxt_s;

  logic [3:0] fire;
  logic [3:0] busy;
  logic [15:0] en16;
  logic [15:0] nd16;
  logic same_lo;
  logic same_hi;
  logic q_in_valid;
  logic q_in_ready;
  logic q_out_valid;
  logic q_out_ready;
  logic [15:0] q_out_data;
  logic [5:0] q_level;

  assign en16 = {s_ff.enu, s_ff.enl};
  assign nd16 = {s_ff.ndu, s_ff.ndl};
  assign same_lo = (s_ff.tsel[3:2] == s_ff.tsel[1:0]);
  assign same_hi = (s_ff.tsel[7:6] == s_ff.tsel[5:4]);

  always_comb
  begin
    for (int g = 0; g < GROUPS; g++)
    begin
      // A group fires from its own selected, already sampled, match pulse.
      fire[g] = s_ff.trig[s_ff.tsel[g*SEL_BITS +: SEL_BITS]]; // RULE_03
      busy[g] = fire[g] || (s_ff.cnt[g] != '0);
    end
  end

  // ==========================================================================
  // Pattern word queue
  // ==========================================================================
  // Software fills the queue; every transfer pops one word into next data,
  // so a burst of patterns runs without waiting on a DMA channel.
  assign q_in_valid = s_ff.ap_vld && s_ff.ap_wr && !s_ff.hready &&
                      (s_ff.ap_lo == IDX_QUEUE[8:0]);
  assign q_out_ready = |fire;

  tpo_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_in_valid(q_in_valid),
    .i_in_data(i_hwdata[15:0]),
    .o_in_ready(q_in_ready),
    .o_out_valid(q_out_valid),
    .o_out_data(q_out_data),
    .i_out_ready(q_out_ready),
    .o_level(q_level)
  );

  // ==========================================================================
  // Read mux
  // ==========================================================================
  function automatic logic [31:0] read_reg(input tpo_st_t st,
                                           input logic [8:0] lo,
                                           input logic s_lo,
                                           input logic s_hi,
                                           input logic [5:0] lvl);
    logic [31:0] r;
    r = '0;
    unique case (lo)
      IDX_PORT_DATA[8:0]: r[15:0] = st.pd;
      IDX_PIN_FUNC_HIGH[8:0]: r[15:0] = st.pfh;
      IDX_PIN_FUNC_LOW[8:0]: r[15:0] = st.pfl;
      IDX_MODE[8:0]: r[7:0] = st.mode;
      IDX_TRIG_SEL[8:0]: r[7:0] = st.tsel;
      IDX_EN_UPPER[8:0]: r[7:0] = st.enu;
      IDX_EN_LOWER[8:0]: r[7:0] = st.enl;
      IDX_ND_UPPER[8:0]: r[7:0] = s_hi ? st.ndu :
                                  {st.ndu[7:4], RSVD_NIBBLE}; // RULE_11
      IDX_ND_LOWER[8:0]: r[7:0] = s_lo ? st.ndl :
                                  {st.ndl[7:4], RSVD_NIBBLE}; // RULE_09
      IDX_ND_UPPER_ALT[8:0]: r[7:0] = s_hi ? RSVD_BYTE :
                                      {RSVD_NIBBLE, st.ndu[3:0]}; // RULE_12
      IDX_ND_LOWER_ALT[8:0]: r[7:0] = s_lo ? RSVD_BYTE : // RULE_15
                                      {RSVD_NIBBLE, st.ndl[3:0]}; // RULE_10
      IDX_GAP[8:0]: r[7:0] = st.gap;
      IDX_QUEUE_LEVEL[8:0]: r[5:0] = lvl;
      default: r = '0;
    endcase
    return r;
  endfunction : read_reg

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb
  begin
    logic [3:0] nib;
    logic [3:0] en;
    logic [15:0] wd;
    logic hit;
    nib = '0;
    hit = 1'b0;
    en = '0;
    wd = i_hwdata[15:0];
    nxt_s = s_ff;
    nxt_s.trig = i_cmp_match; // RULE_16
    nxt_s.hresp = 1'b0;

    // Pattern transfer, one nibble per group.
    for (int g = 0; g < GROUPS; g++)
    begin
      en = en16[g*GROUP_BITS +: GROUP_BITS]; // RULE_06
      nib = nd16[g*GROUP_BITS +: GROUP_BITS];
      nib = (s_ff.pd[g*GROUP_BITS +: GROUP_BITS] & ~en) | (nib & en);
      if (fire[g]) // RULE_01
      begin
        if (s_ff.mode[g])
        begin
          // Falling bits act now; rising bits wait out the gap.
          nxt_s.pd[g*GROUP_BITS +: GROUP_BITS] =
            s_ff.pd[g*GROUP_BITS +: GROUP_BITS] & nib; // RULE_04
          nxt_s.pend[g] = nib;
          nxt_s.cnt[g] = (s_ff.gap == '0) ? GAP_ONE : s_ff.gap;
        end
        else
        begin
          nxt_s.pd[g*GROUP_BITS +: GROUP_BITS] = nib; // RULE_13
          nxt_s.cnt[g] = '0;
        end
      end
      else if (s_ff.cnt[g] != '0)
      begin
        nxt_s.cnt[g] = s_ff.cnt[g] - 1'b1;
        if (s_ff.cnt[g] == GAP_ONE)
        begin
          nxt_s.pd[g*GROUP_BITS +: GROUP_BITS] =
            (s_ff.pd[g*GROUP_BITS +: GROUP_BITS] & ~en) |
            (s_ff.pend[g] & en); // RULE_04
        end
      end
    end

    // A match that some enabled group uses asks DMA for the next word.
    for (int c = 0; c < GROUPS; c++)
    begin
      nxt_s.dma[c] = 1'b0;
      for (int g = 0; g < GROUPS; g++)
      begin
        if ((s_ff.tsel[g*SEL_BITS +: SEL_BITS] == c[1:0]) &&
            (en16[g*GROUP_BITS +: GROUP_BITS] != '0))
        begin
          nxt_s.dma[c] = nxt_s.dma[c] | s_ff.trig[c]; // RULE_05
        end
      end
    end

    // Register writes in the data phase.
    if (s_ff.ap_vld && s_ff.ap_wr && s_ff.hready)
    begin
      unique case (s_ff.ap_lo)
        IDX_PORT_DATA[8:0]: nxt_s.pd = (nxt_s.pd & en16) | (wd & ~en16); // RULE_07
        IDX_PIN_FUNC_HIGH[8:0]: nxt_s.pfh = wd;
        IDX_PIN_FUNC_LOW[8:0]: nxt_s.pfl = wd;
        IDX_MODE[8:0]: nxt_s.mode = {RSVD_NIBBLE, wd[3:0]};
        IDX_TRIG_SEL[8:0]: nxt_s.tsel = wd[7:0];
        IDX_EN_UPPER[8:0]: nxt_s.enu = wd[7:0];
        IDX_EN_LOWER[8:0]: nxt_s.enl = wd[7:0];
        IDX_ND_UPPER[8:0]:
        begin
          nxt_s.ndu[7:4] = wd[7:4];
          if (same_hi)
          begin
            nxt_s.ndu[3:0] = wd[3:0]; // RULE_11
          end
        end
        IDX_ND_LOWER[8:0]:
        begin
          nxt_s.ndl[7:4] = wd[7:4];
          if (same_lo)
          begin
            nxt_s.ndl[3:0] = wd[3:0]; // RULE_09
          end
        end
        IDX_ND_UPPER_ALT[8:0]:
        begin
          if (!same_hi)
          begin
            nxt_s.ndu[3:0] = wd[3:0]; // RULE_12
          end
        end
        IDX_ND_LOWER_ALT[8:0]:
        begin
          if (!same_lo)
          begin
            nxt_s.ndl[3:0] = wd[3:0]; // RULE_10
          end
        end
        IDX_GAP[8:0]: nxt_s.gap = wd[7:0];
        default: nxt_s.gap = nxt_s.gap;
      endcase
    end

    // A queued word refills next data of the groups that just fired.
    if (q_out_valid && q_out_ready)
    begin
      for (int g = 0; g < GROUPS / 2; g++)
      begin
        if (fire[g])
        begin
          nxt_s.ndl[g*GROUP_BITS +: GROUP_BITS] =
            q_out_data[g*GROUP_BITS +: GROUP_BITS];
        end
        if (fire[g+2])
        begin
          nxt_s.ndu[g*GROUP_BITS +: GROUP_BITS] =
            q_out_data[(g+2)*GROUP_BITS +: GROUP_BITS];
        end
      end
    end

    // Bus pipeline.
    if (s_ff.ap_vld && s_ff.hready)
    begin
      nxt_s.ap_vld = 1'b0;
    end
    if (q_in_valid && q_in_ready)
    begin
      nxt_s.ap_vld = 1'b0;
      nxt_s.hready = 1'b1;
    end
    if (i_hsel && i_htrans[1] && i_hready)
    begin
      hit = (i_haddr[29:26] == IDX_AREA); // RULE_08
      nxt_s.ap_vld = hit;
      nxt_s.ap_wr = i_hwrite;
      nxt_s.ap_lo = hit ? i_haddr[10:2] : '0; // RULE_08
      nxt_s.hrdata = hit ? read_reg(s_ff, i_haddr[10:2], same_lo, same_hi,
                                    q_level) : '0;
      // Queue writes wait until the queue has room.
      nxt_s.hready = !(hit && i_hwrite &&
                       (i_haddr[10:2] == IDX_QUEUE[8:0]));
    end

    for (int b = 0; b < 8; b++)
    begin
      nxt_s.oen[b] = (s_ff.pfl[b*2 +: 2] == PIN_FUNC_PATTERN) &&
                     s_ff.enl[b]; // RULE_02
      nxt_s.oen[b+8] = (s_ff.pfh[b*2 +: 2] == PIN_FUNC_PATTERN) &&
                       s_ff.enu[b]; // RULE_14
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      s_ff <= '0;
      s_ff.hready <= 1'b1;
      s_ff.pd <= RST_PORT_DATA;
      s_ff.pfh <= RST_PIN_FUNC;
      s_ff.pfl <= RST_PIN_FUNC;
      s_ff.mode <= RST_MODE;
      s_ff.tsel <= RST_TRIG_SEL;
      s_ff.enu <= RST_EN;
      s_ff.enl <= RST_EN;
      s_ff.ndu <= RST_ND;
      s_ff.ndl <= RST_ND;
      s_ff.gap <= RST_GAP;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign o_hreadyout = s_ff.hready;
  assign o_hrdata = s_ff.hrdata;
  assign o_hresp = s_ff.hresp;
  assign o_pattern = s_ff.pd;
  assign o_pattern_oe = s_ff.oen;
  assign o_dma_req = s_ff.dma;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  sequence s_g0_fire_plain;
    fire[0] && !s_ff.mode[0];
  endsequence

  property p_xfer_g0;
    s_g0_fire_plain |=> o_pattern[3:0] ==
      (($past(s_ff.pd[3:0]) & ~$past(s_ff.enl[3:0])) |
       ($past(s_ff.ndl[3:0]) & $past(s_ff.enl[3:0])));
  endproperty
  a_xfer_g0: assert property (p_xfer_g0) // RULE_13
    else $error("group 0 did not take next data");

  property p_sample_g3;
    (i_cmp_match[s_ff.tsel[7:6]] && !s_ff.mode[3] &&
     $stable(s_ff.tsel) [*1]) ##1 ($stable(s_ff.tsel) && s_ff.enu[7:4] != '0)
      |-> busy[3];
  endproperty
  a_sample_g3: assert property (p_sample_g3) // RULE_16
    else $error("group 3 missed its sampled trigger");

  property p_port_lock;
    ((o_pattern ^ $past(o_pattern)) & $past(en16) &
     ~{{4{$past(busy[3])}}, {4{$past(busy[2])}},
       {4{$past(busy[1])}}, {4{$past(busy[0])}}}) == '0;
  endproperty
  a_port_lock: assert property (p_port_lock) // RULE_07
    else $error("enabled port bit changed without a transfer");

  property p_dma;
    (i_cmp_match[0] && s_ff.tsel[1:0] == 2'h0 && s_ff.enl[3:0] != '0 &&
     !(s_ff.ap_vld && s_ff.ap_wr)) ##1 1'b1 |=> o_dma_req[0];
  endproperty
  a_dma: assert property (p_dma) // RULE_05
    else $error("used compare match gave no DMA request");

  sequence s_rd_alt_lo;
    i_hsel && i_htrans == HTRANS_NONSEQ && i_hready && !i_hwrite &&
    i_haddr[29:26] == IDX_AREA && i_haddr[10:2] == IDX_ND_LOWER_ALT[8:0] &&
    same_lo;
  endsequence

  property p_rsvd_alt;
    s_rd_alt_lo |=> o_hrdata[7:0] == RSVD_BYTE;
  endproperty
  a_rsvd_alt: assert property (p_rsvd_alt) // RULE_15
    else $error("reserved next data byte did not read as ones");

  property p_split_lo;
    (i_hsel && i_htrans[1] && i_hready && !i_hwrite &&
     i_haddr[29:26] == IDX_AREA && i_haddr[10:2] == IDX_ND_LOWER[8:0] &&
     !same_lo) |=> o_hrdata[7:0] == {$past(s_ff.ndl[7:4]), RSVD_NIBBLE};
  endproperty
  a_split_lo: assert property (p_split_lo) // RULE_10
    else $error("split lower next data read wrong");

  property p_pin_en;
    ##1 o_pattern_oe[0] == ($past(s_ff.pfl[1:0]) == PIN_FUNC_PATTERN &&
                            $past(s_ff.enl[0]));
  endproperty
  a_pin_en: assert property (p_pin_en) // RULE_02
    else $error("pin 0 output enable wrong");

  property p_nov;
    (fire[0] && s_ff.mode[0] && s_ff.gap > GAP_ONE) |=>
      ((o_pattern[3:0] & ~$past(o_pattern[3:0]) &
        $past(s_ff.enl[3:0])) == '0) [*2];
  endproperty
  a_nov: assert property (p_nov) // RULE_04
    else $error("rising pattern bit inside non-overlap gap");

endmodule : tpo_top
`default_nettype wire

// ---- test/tpo_timer_model.sv ----
// Behavioural timer compare-match source and DMA request counter.
`timescale 1ns/1ps
`default_nettype none
module tpo_timer_model
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Compare-match pulses towards the block
  output logic [3:0] o_cmp_match,
  // DMA requests from the block, counted per channel
  input wire logic [3:0] i_dma_req,
  output logic [31:0] o_dma_cnt
);
  // ==========================================================================
  // Compare-match source
  // ==========================================================================
  initial o_cmp_match = 4'h0;

  // Call right after a rising edge; the pulse lasts exactly one cycle.
  task automatic fire(input int ch);
    o_cmp_match[ch[1:0]] <= 1'b1;
    @(posedge i_clk);
    o_cmp_match <= 4'h0;
  endtask : fire

  // ==========================================================================
  // DMA controller side
  // ==========================================================================
  always @(posedge i_clk)
  begin
    for (int c = 0; c < 4; c++)
    begin
      if (i_srst)
        o_dma_cnt[8*c+:8] <= 8'h00;
      else if (i_dma_req[c] === 1'b1)
        o_dma_cnt[8*c+:8] <= o_dma_cnt[8*c+:8] + 8'h01;
    end
  end
endmodule : tpo_timer_model
`default_nettype wire

// ---- test/tpo_top_test.sv ----
// Self-checking bench of the pattern block: registers, triggers and queue.
`timescale 1ns/1ps
`default_nettype none
module tpo_top_test;
  import tpo_pkg::*;
  // ==========================================================================
  // Signals and tables
  // ==========================================================================
  logic i_clk, i_srst, hsel, hwrite, snap, rd_ph;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, seed;
  logic [15:0] pv, w[33];
  logic [34:0] ent, exp_q[$];
  int error_cnt, check_count;
  wire logic hrdy, hresp;
  wire logic [31:0] hrdata, dma_cnt;
  wire logic [15:0] pat, oe;
  wire logic [3:0] cmp, dreq;
  localparam logic [27:0] RI[16] = '{IDX_PORT_DATA, IDX_PIN_FUNC_HIGH,
    IDX_PIN_FUNC_LOW, IDX_MODE, IDX_TRIG_SEL, IDX_EN_UPPER, IDX_EN_LOWER,
    IDX_ND_UPPER, IDX_ND_LOWER, IDX_ND_UPPER_ALT, IDX_ND_LOWER_ALT, IDX_GAP,
    IDX_QUEUE_LEVEL, 28'h5FFFFFB, 28'h4FFFFF0, IDX_MODE ^ 28'h0ABCE00};
  localparam logic [7:0] RE[16] = '{8'h00, 8'h00, 8'h00, 8'hF0, 8'hFF,
    8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h01, 8'h00, 8'h00, 8'h00,
    8'hF0};
  localparam logic [27:0] WI[8] = '{IDX_ND_LOWER, IDX_ND_LOWER_ALT,
    IDX_ND_UPPER, IDX_ND_UPPER_ALT, IDX_ND_LOWER, IDX_ND_LOWER_ALT,
    IDX_ND_UPPER, IDX_ND_UPPER_ALT};
  localparam logic [7:0] WD[8] = '{8'hA5, 8'h3C, 8'h71, 8'h59, 8'h5A,
    8'h00, 8'h3C, 8'h00};
  localparam logic [7:0] WR[8] = '{8'hAF, 8'hFC, 8'h7F, 8'hF9, 8'h5A,
    8'hFF, 8'h3C, 8'hFF};

  tpo_top DUT (.i_clk(i_clk), .i_srst(i_srst), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy),
    .o_hreadyout(hrdy), .o_hrdata(hrdata), .o_hresp(hresp),
    .i_cmp_match(cmp), .o_pattern(pat), .o_pattern_oe(oe),
    .o_dma_req(dreq));
  tpo_timer_model u_tmr (.i_clk(i_clk), .i_srst(i_srst),
    .o_cmp_match(cmp), .i_dma_req(dreq), .o_dma_cnt(dma_cnt));

  initial
  begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  // ==========================================================================
  // Tasks
  // ==========================================================================
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : xs

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want)
    begin
      error_cnt++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask : chk

  task automatic end_of_test();
    $display("Checks %0d, errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  // Single AHB transfer; each phase is held until hready is seen high.
  task automatic bus(input bit wr, input logic [27:0] idx,
                     input logic [31:0] d);
    snap <= 1'b0;
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= {2'h0, idx, 2'h0};
    do @(posedge i_clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge i_clk); while (hrdy !== 1'b1);
  endtask : bus

  task automatic wr(input logic [27:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d);
  endtask : wr

  task automatic rd(input logic [27:0] idx, input logic [31:0] e);
    exp_q.push_back({3'h0, e});
    bus(1'b0, idx, 32'h0);
  endtask : rd

  // Kind 1 enables, 2 DMA counts, 3 pins, 4 hready; snap stays up so that
  // back-to-back peeks never assign it twice in one time step.
  task automatic peek(input logic [2:0] k, input logic [31:0] e);
    exp_q.push_back({k, e});
    snap <= 1'b1;
    @(posedge i_clk);
  endtask : peek

  task automatic tick(input int n);
    snap <= 1'b0;
    repeat (n) @(posedge i_clk);
  endtask : tick

  // ==========================================================================
  // Result monitor
  // ==========================================================================
  always @(posedge i_clk)
  begin
    if (snap === 1'b1 || (rd_ph === 1'b1 && hrdy === 1'b1))
    begin
      ent = exp_q.pop_front();
      case (ent[34:32])
        3'h0: chk(hrdata, ent[31:0]);
        3'h1: chk({16'h0, oe}, ent[31:0]);
        3'h2: chk(dma_cnt, ent[31:0]);
        3'h3: chk({16'h0, pat}, ent[31:0]);
        default: chk({30'h0, hresp, hrdy}, ent[31:0]);
      endcase
    end
    rd_ph <= hrdy ? (hsel & htrans[1] & ~hwrite) : rd_ph;
  end

  initial
  begin
    repeat (20000) @(posedge i_clk);
    error_cnt++;
    end_of_test();
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    i_srst = 1'b1;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    snap = 1'b0;
    rd_ph = 1'b0;
    error_cnt = 0;
    check_count = 0;
    seed = 32'hD4714B23;
    repeat (10) @(posedge i_clk);
    i_srst <= 1'b0;
    @(posedge i_clk);
    for (int i = 0; i < 16; i++) rd(RI[i], {24'h0, RE[i]});
    wr(IDX_PIN_FUNC_HIGH, 32'h5555);
    wr(IDX_PIN_FUNC_LOW, 32'h5554);
    wr(IDX_EN_UPPER, 32'hF0);
    wr(IDX_EN_LOWER, 32'h0F);
    tick(2);
    peek(3'h1, 32'hF00E);
    wr(IDX_PIN_FUNC_LOW, 32'h5555);
    wr(IDX_EN_UPPER, 32'hFF);
    wr(IDX_EN_LOWER, 32'hFF);
    wr(IDX_TRIG_SEL, 32'hE4);
    for (int i = 0; i < 4; i++)
    begin
      wr(WI[i], {24'h0, WD[i]});
      rd(WI[i], {24'h0, WR[i]});
    end
    pv = 16'h0;
    for (int c = 0; c < 4; c++)
    begin
      u_tmr.fire(c);
      tick(2);
      pv[4*c+:4] = 4'(16'h79AC >> (4 * c));
      rd(IDX_PORT_DATA, {16'h0, pv});
    end
    peek(3'h2, 32'h01010101);
    wr(IDX_PORT_DATA, 32'hFFFF);
    rd(IDX_PORT_DATA, 32'h79AC);
    wr(IDX_EN_UPPER, 32'h00);
    wr(IDX_PORT_DATA, 32'h0000);
    rd(IDX_PORT_DATA, 32'h00AC);
    wr(IDX_EN_UPPER, 32'hFF);
    wr(IDX_TRIG_SEL, 32'h00);
    for (int i = 4; i < 8; i++)
    begin
      wr(WI[i], {24'h0, WD[i]});
      rd(WI[i], {24'h0, WR[i]});
    end
    u_tmr.fire(0);
    tick(2);
    rd(IDX_PORT_DATA, 32'h3C5A);
    wr(IDX_MODE, 32'h01);
    rd(IDX_MODE, 32'hF1);
    wr(IDX_GAP, 32'h03);
    wr(IDX_ND_LOWER, 32'h55);
    u_tmr.fire(0);
    @(posedge i_clk);
    peek(3'h3, 32'h3C50);
    peek(3'h3, 32'h3C50);
    peek(3'h3, 32'h3C50);
    peek(3'h3, 32'h3C55);
    tick(1);
    wr(IDX_MODE, 32'h00);
    // The queue is filled to the brim, then one more word must stall.
    for (int i = 0; i < 33; i++)
    begin
      seed = xs(seed);
      w[i] = seed[15:0];
    end
    for (int i = 0; i < 32; i++) wr(IDX_QUEUE, {16'h0, w[i]});
    rd(IDX_QUEUE_LEVEL, 32'h20);
    fork
      wr(IDX_QUEUE, {16'h0, w[32]});
      begin
        repeat (3) @(posedge i_clk);
        peek(3'h4, 32'h0);
        tick(0);
        u_tmr.fire(0);
      end
    join
    rd(IDX_QUEUE_LEVEL, 32'h20);
    rd(IDX_PORT_DATA, 32'h3C55);
    for (int i = 1; i < 34; i++)
    begin
      u_tmr.fire(0);
      tick(2);
      rd(IDX_PORT_DATA, {16'h0, w[i-1]});
    end
    rd(IDX_QUEUE_LEVEL, 32'h0);
    end_of_test();
  end
endmodule : tpo_top_test
`default_nettype wire
